/* File: include/spm_cfg.svh */
// Timing counts, input channel map and reset levels of the power and reset manager
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH

`define SPM_CLK_MHZ       250
`define SPM_CNT_W         21

// Input filter window, shorter than the 16 ms least press so a legal press always passes
`define SPM_FILT_TIME_US  8000
`define SPM_FILT_CYCLES   (`SPM_FILT_TIME_US * `SPM_CLK_MHZ)
// Carrier reset pulse length
`define SPM_RST_TIME_US   1000
`define SPM_RST_CYCLES    (`SPM_RST_TIME_US * `SPM_CLK_MHZ)
// Lead time of the suspend warning before the sleep outputs move
`define SPM_WARN_TIME_US  100
`define SPM_WARN_CYCLES   (`SPM_WARN_TIME_US * `SPM_CLK_MHZ)

// Filtered input channels
`define SPM_NUM_IN        6
`define SPM_IN_PWR_BTN    0
`define SPM_IN_RST_BTN    1
`define SPM_IN_PWR_GOOD   2
`define SPM_IN_12V_OK     3
`define SPM_IN_PCIE_WAKE  4
`define SPM_IN_GEN_WAKE   5
// Idle level of each channel after reset: buttons and wakes released, supplies not yet good
`define SPM_IN_RESET_LVL  6'h33

`endif

/* File: include/spm_pkg.sv */
// Types shared by the power and reset manager modules
`include "spm_cfg.svh"
package spm_pkg;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_PWRUP,
        ST_RESET,
        ST_ON,
        ST_WARN,
        ST_RAM,
        ST_DISK
    } spm_state_e;

    typedef enum logic [1:0] {
        SLP_RAM,
        SLP_DISK,
        SLP_OFF
    } spm_sleep_e;

    typedef enum logic [2:0] {
        CAUSE_NONE,
        CAUSE_BUTTON,
        CAUSE_POWER,
        CAUSE_SUPPLY,
        CAUSE_WATCHDOG,
        CAUSE_SOFTWARE
    } spm_cause_e;

    typedef logic [`SPM_CNT_W-1:0] spm_cnt_t;
    typedef logic [`SPM_NUM_IN-1:0] spm_in_t;

    typedef struct packed {
        spm_in_t                      sync1;
        spm_in_t                      sync2;
        spm_in_t                      level;
        spm_in_t                      fall;
        spm_in_t                      rise;
        logic [`SPM_NUM_IN-1:0][`SPM_CNT_W-1:0] cnt;
    } spm_filt_s;

    typedef struct packed {
        logic carrier_reset_n;
        logic suspend_warning_n;
        logic sleep_ram_n;
        logic sleep_disk_n;
        logic soft_off_n;
    } spm_out_s;

    typedef struct packed {
        spm_state_e st;
        spm_sleep_e tgt;
        spm_cnt_t   cnt;
        spm_out_s   pins;
        logic       watchdog_event_out;
        spm_cause_e cause;
    } spm_core_s;

endpackage

/* File: include/spm_filt_if.sv */
// Raw inputs toward the filter and clean levels and edges back to the sequencer
`timescale 1ns/10ps
interface spm_filt_if;
    spm_pkg::spm_in_t raw;
    spm_pkg::spm_in_t level;
    spm_pkg::spm_in_t fall;
    spm_pkg::spm_in_t rise;

    modport filt (
        input  raw,
        output level,
        output fall,
        output rise
    );
    modport user (
        output raw,
        input  level,
        input  fall,
        input  rise
    );
endinterface

/* File: core/spm_input_filter.sv */
// Two-stage synchroniser and glitch filter with edge pulses for each input channel
`timescale 1ns/10ps
`include "spm_cfg.svh"
module spm_input_filter #(
    parameter int unsigned FILT_CYCLES = `SPM_FILT_CYCLES
) (
    input  wire logic ref_clk, // 250 MHz clock
    input  wire logic srst,    // Synchronous reset, active high
    spm_filt_if.filt  fi       // Raw in, filtered out
);
    localparam spm_pkg::spm_cnt_t FILT_LAST = `SPM_CNT_W'(FILT_CYCLES - 1);

    spm_pkg::spm_filt_s s_r;
    spm_pkg::spm_filt_s s_nxt;

    always_comb begin
        s_nxt       = s_r;
        s_nxt.sync1 = fi.raw;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.fall  = '0;
        s_nxt.rise  = '0;
        // A change must hold for the whole window; anything shorter is dropped
        for (int i = 0; i < `SPM_NUM_IN; i++) begin
            if (s_r.sync2[i] == s_r.level[i]) begin
                s_nxt.cnt[i] = '0;
            end else if (s_r.cnt[i] >= FILT_LAST) begin // RL16
                s_nxt.cnt[i]   = '0;
                s_nxt.level[i] = s_r.sync2[i];
                s_nxt.fall[i]  = ~s_r.sync2[i];
                s_nxt.rise[i]  = s_r.sync2[i];
            end else begin
                s_nxt.cnt[i] = s_r.cnt[i] + `SPM_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_r       <= '0;
            s_r.sync1 <= `SPM_IN_RESET_LVL;
            s_r.sync2 <= `SPM_IN_RESET_LVL;
            s_r.level <= `SPM_IN_RESET_LVL;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign fi.level = s_r.level;
    assign fi.fall  = s_r.fall;
    assign fi.rise  = s_r.rise;
endmodule

/* File: core/spm_power_manager.sv */
// Power, sleep-state and carrier reset sequencer of the module toward its carrier board
`timescale 1ns/10ps
`include "spm_cfg.svh"

// Overview of operation
// (RL1) Power button falling edge leaves soft off
// (RL2) Carrier holds buttons low 16 ms minimum
// (RL3) Power button still watched in extended soft off
// (RL4) Reset button active low, edge triggered
// (RL5) One reset per press, never held
// (RL6) Carrier reset on button, power, 12V, watchdog, software
// (RL7) Power-good high means main power good
// (RL8) Suspend-to-RAM output low in that state
// (RL9) Carrier may invert RAM output for supply
// (RL10) Suspend-to-disk output low in that state
// (RL11) Soft-off output asserted in soft off
// (RL12) Suspend warning asserted before low-power entry
// (RL13) Watchdog event output flags a time-out
// (RL14) PCI Express wake input resumes system
// (RL15) General wake input resumes system
// (RL16) Inputs synchronised and filtered before edges
module spm_power_manager #(
    parameter int unsigned FILT_CYCLES = `SPM_FILT_CYCLES, // Input glitch window
    parameter int unsigned RST_CYCLES  = `SPM_RST_CYCLES,  // Carrier reset pulse
    parameter int unsigned WARN_CYCLES = `SPM_WARN_CYCLES  // Suspend warning lead
) (
    input  wire logic                ref_clk,            // 250 MHz clock
    input  wire logic                srst,               // Synchronous reset, active high
    input  wire logic                power_button_n,     // Power button, active low
    input  wire logic                reset_button_n,     // Reset button, active low
    input  wire logic                main_power_good,    // Main supply good, high
    input  wire logic                main_12v_input,     // 12 V above minimum, high
    input  wire logic                pcie_wake_n,        // PCI Express wake, active low
    input  wire logic                general_wake_n,     // Keyboard or mouse wake, active low
    input  wire logic                watchdog_timeout,   // Watchdog expiry, one-cycle pulse
    input  wire logic                watchdog_clear,     // Clears the watchdog flag, pulse
    input  wire logic                sw_reset_req,       // Software reset request, pulse
    input  wire logic                sw_sleep_req,       // Software sleep request, pulse
    input  spm_pkg::spm_sleep_e      sw_sleep_target,    // Sleep state for the request
    input  wire logic                extended_soft_off,  // Extended soft off mode, high
    output logic                     carrier_reset_n,    // Carrier reset, active low
    output logic                     suspend_warning_n,  // Suspend imminent, active low
    output logic                     sleep_ram_n,        // Suspend to RAM, active low
    output logic                     sleep_disk_n,       // Suspend to disk, active low
    output logic                     soft_off_n,         // Soft off, active low
    output logic                     watchdog_event_out, // Watchdog time-out seen, high
    output spm_pkg::spm_state_e      power_state,        // Current sequencer state
    output spm_pkg::spm_cause_e      reset_cause         // Source of the last carrier reset
);
    localparam spm_pkg::spm_cnt_t RST_LAST  = `SPM_CNT_W'(RST_CYCLES - 1);
    localparam spm_pkg::spm_cnt_t WARN_LAST = `SPM_CNT_W'(WARN_CYCLES - 1);

    spm_filt_if fif ();

    spm_input_filter #(
        .FILT_CYCLES (FILT_CYCLES)
    ) u_filt (
        .ref_clk (ref_clk),
        .srst    (srst),
        .fi      (fif.filt)
    );

    // Every button, supply and wake pin goes through the filter; the watchdog, software and extended soft off inputs are used raw
    always_comb begin
        fif.raw                     = '0;
        fif.raw[`SPM_IN_PWR_BTN]    = power_button_n;   // RL16
        fif.raw[`SPM_IN_RST_BTN]    = reset_button_n;   // RL16
        fif.raw[`SPM_IN_PWR_GOOD]   = main_power_good;  // RL16
        fif.raw[`SPM_IN_12V_OK]     = main_12v_input;   // RL16
        fif.raw[`SPM_IN_PCIE_WAKE]  = pcie_wake_n;      // RL16
        fif.raw[`SPM_IN_GEN_WAKE]   = general_wake_n;   // RL16
    end

    logic pwr_btn_fall;
    logic rst_btn_fall;
    logic pwr_good;
    logic supply_ok;
    logic wake_fall;

    assign pwr_btn_fall = fif.fall[`SPM_IN_PWR_BTN];   // RL1
    assign rst_btn_fall = fif.fall[`SPM_IN_RST_BTN];   // RL4
    assign pwr_good     = fif.level[`SPM_IN_PWR_GOOD]; // RL7
    assign supply_ok    = fif.level[`SPM_IN_12V_OK];
    assign wake_fall    = fif.fall[`SPM_IN_PCIE_WAKE]  // RL14
                        | fif.fall[`SPM_IN_GEN_WAKE];  // RL15

    // Pin levels of each state; deeper states keep the shallower lines asserted
    // so an inverted RAM line stays a valid supply enable in every off state
    function automatic spm_pkg::spm_out_s pins_of(spm_pkg::spm_state_e st);
        spm_pkg::spm_out_s p;
        p.carrier_reset_n   = 1'b0;
        p.suspend_warning_n = 1'b1;
        p.sleep_ram_n       = 1'b1;
        p.sleep_disk_n      = 1'b1;
        p.soft_off_n        = 1'b1;
        case (st)
            spm_pkg::ST_OFF: begin
                p.suspend_warning_n = 1'b0;
                p.sleep_ram_n       = 1'b0;
                p.sleep_disk_n      = 1'b0;
                p.soft_off_n        = 1'b0; // RL11
            end
            spm_pkg::ST_PWRUP,
            spm_pkg::ST_RESET: begin
                p.carrier_reset_n = 1'b0;
            end
            spm_pkg::ST_ON: begin
                p.carrier_reset_n = 1'b1;
            end
            spm_pkg::ST_WARN: begin
                p.carrier_reset_n   = 1'b1;
                p.suspend_warning_n = 1'b0; // RL12
            end
            spm_pkg::ST_RAM: begin
                p.suspend_warning_n = 1'b0;
                p.sleep_ram_n       = 1'b0; // RL8
            end
            spm_pkg::ST_DISK: begin
                p.suspend_warning_n = 1'b0;
                p.sleep_ram_n       = 1'b0;
                p.sleep_disk_n      = 1'b0; // RL10
            end
            default: begin
                p.carrier_reset_n = 1'b0;
            end
        endcase
        return p;
    endfunction

    spm_pkg::spm_core_s s_r;
    spm_pkg::spm_core_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        case (s_r.st)
            spm_pkg::ST_OFF: begin
                // Only the power button leaves extended soft off
                if (pwr_btn_fall || (wake_fall && !extended_soft_off)) begin // RL1 RL3
                    s_nxt.st  = spm_pkg::ST_PWRUP;
                    s_nxt.cnt = '0;
                end
            end
            spm_pkg::ST_PWRUP: begin
                // Carrier stays in reset until both supplies report good
                if (pwr_good && supply_ok) begin // RL7
                    s_nxt.st  = spm_pkg::ST_RESET;
                    s_nxt.cnt = '0;
                end
            end
            spm_pkg::ST_RESET: begin
                if (!pwr_good || !supply_ok) begin
                    s_nxt.st    = spm_pkg::ST_PWRUP;
                    s_nxt.cause = pwr_good ? spm_pkg::CAUSE_SUPPLY : spm_pkg::CAUSE_POWER;
                end else if (s_r.cnt >= RST_LAST) begin // RL5
                    s_nxt.st  = spm_pkg::ST_ON;
                    s_nxt.cnt = '0;
                end else begin
                    s_nxt.cnt = s_r.cnt + `SPM_CNT_W'(1);
                end
            end
            spm_pkg::ST_ON: begin
                if (!pwr_good) begin // RL6 RL7
                    s_nxt.st    = spm_pkg::ST_PWRUP;
                    s_nxt.cause = spm_pkg::CAUSE_POWER;
                end else if (!supply_ok) begin // RL6
                    s_nxt.st    = spm_pkg::ST_PWRUP;
                    s_nxt.cause = spm_pkg::CAUSE_SUPPLY;
                end else if (rst_btn_fall) begin // RL4 RL5 RL6
                    s_nxt.st    = spm_pkg::ST_RESET;
                    s_nxt.cnt   = '0;
                    s_nxt.cause = spm_pkg::CAUSE_BUTTON;
                end else if (watchdog_timeout) begin // RL6
                    s_nxt.st    = spm_pkg::ST_RESET;
                    s_nxt.cnt   = '0;
                    s_nxt.cause = spm_pkg::CAUSE_WATCHDOG;
                end else if (sw_reset_req) begin // RL6
                    s_nxt.st    = spm_pkg::ST_RESET;
                    s_nxt.cnt   = '0;
                    s_nxt.cause = spm_pkg::CAUSE_SOFTWARE;
                end else if (pwr_btn_fall) begin
                    s_nxt.st  = spm_pkg::ST_WARN;
                    s_nxt.tgt = spm_pkg::SLP_OFF;
                    s_nxt.cnt = '0;
                end else if (sw_sleep_req) begin
                    s_nxt.st  = spm_pkg::ST_WARN;
                    s_nxt.tgt = sw_sleep_target;
                    s_nxt.cnt = '0;
                end
            end
            spm_pkg::ST_WARN: begin
                // Sleep lines move only after the warning has stood its full lead time
                if (s_r.cnt >= WARN_LAST) begin // RL12
                    s_nxt.cnt = '0;
                    case (s_r.tgt)
                        spm_pkg::SLP_RAM:  s_nxt.st = spm_pkg::ST_RAM;
                        spm_pkg::SLP_DISK: s_nxt.st = spm_pkg::ST_DISK;
                        default:           s_nxt.st = spm_pkg::ST_OFF;
                    endcase
                end else begin
                    s_nxt.cnt = s_r.cnt + `SPM_CNT_W'(1);
                end
            end
            spm_pkg::ST_RAM,
            spm_pkg::ST_DISK: begin
                if (pwr_btn_fall || wake_fall) begin // RL14 RL15
                    s_nxt.st  = spm_pkg::ST_PWRUP;
                    s_nxt.cnt = '0;
                end
            end
            default: begin
                s_nxt.st  = spm_pkg::ST_OFF;
                s_nxt.cnt = '0;
            end
        endcase

        // A time-out landing on a clear still leaves the flag set
        if (watchdog_timeout) begin // RL13
            s_nxt.watchdog_event_out = 1'b1;
        end else if (watchdog_clear) begin
            s_nxt.watchdog_event_out = 1'b0;
        end

        // Pins follow the next state so that they leave a flop together with it
        s_nxt.pins = pins_of(s_nxt.st); // RL6 RL8 RL10 RL11 RL12
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_r       <= '0;
            s_r.st    <= spm_pkg::ST_OFF;
            s_r.tgt   <= spm_pkg::SLP_OFF;
            s_r.cause <= spm_pkg::CAUSE_NONE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign carrier_reset_n    = s_r.pins.carrier_reset_n;
    assign suspend_warning_n  = s_r.pins.suspend_warning_n;
    assign sleep_ram_n        = s_r.pins.sleep_ram_n;
    assign sleep_disk_n       = s_r.pins.sleep_disk_n;
    assign soft_off_n         = s_r.pins.soft_off_n;
    assign watchdog_event_out = s_r.watchdog_event_out;
    assign power_state        = s_r.st;
    assign reset_cause        = s_r.cause;
endmodule

/* File: dv/spm_pm_chk.sv */
// Port-level checker of the power and reset manager sequencing
`timescale 1ns/10ps
module spm_pm_chk #(
    parameter int unsigned FILT_CYCLES = 4, // Input glitch window
    parameter int unsigned RST_CYCLES  = 8  // Carrier reset pulse
) (
    input wire logic          ref_clk,            // Clock
    input wire logic          srst,               // Synchronous reset
    input wire logic          main_power_good,    // Supply good
    input wire logic          watchdog_timeout,   // Watchdog expiry pulse
    input wire logic          watchdog_clear,     // Watchdog clear pulse
    input wire logic          sw_reset_req,       // Software reset pulse
    input wire logic          carrier_reset_n,    // Carrier reset
    input wire logic          suspend_warning_n,  // Suspend warning
    input wire logic          sleep_ram_n,        // Suspend to RAM
    input wire logic          sleep_disk_n,       // Suspend to disk
    input wire logic          soft_off_n,         // Soft off
    input wire logic          watchdog_event_out, // Watchdog flag
    input spm_pkg::spm_state_e power_state         // Sequencer state
);
    int unsigned rst_cnt;
    int unsigned pg_cnt;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    // Counters stand in for waits far longer than a repetition can unroll
    always_ff @(posedge ref_clk) begin
        rst_cnt <= (power_state == spm_pkg::ST_RESET) ? rst_cnt + 1 : 0;
        pg_cnt  <= (srst || main_power_good) ? 0 : pg_cnt + 1;
    end

    sequence s_sw_reset;
        power_state == spm_pkg::ST_ON && sw_reset_req;
    endsequence
    sequence s_wdog_clear;
        watchdog_clear && !watchdog_timeout;
    endsequence

    a_off_pins: assert property (power_state == spm_pkg::ST_OFF |-> !soft_off_n && !sleep_disk_n && !sleep_ram_n)
        else $error("Soft off without all sleep outputs low");
    a_ram_pins: assert property (power_state == spm_pkg::ST_RAM |-> !sleep_ram_n && sleep_disk_n && soft_off_n)
        else $error("RAM sleep outputs wrong");
    a_disk_pins: assert property (power_state == spm_pkg::ST_DISK |-> !sleep_disk_n && !sleep_ram_n && soft_off_n)
        else $error("Disk sleep outputs wrong");
    a_warn_pin: assert property (power_state == spm_pkg::ST_WARN |-> !suspend_warning_n && sleep_ram_n)
        else $error("Suspend warning not shown ahead of sleep");
    a_warn_first: assert property ($past(power_state) == spm_pkg::ST_ON |->
            !(power_state inside {spm_pkg::ST_RAM, spm_pkg::ST_DISK, spm_pkg::ST_OFF}))
        else $error("Low-power state entered without warning");
    a_sw_reset: assert property (s_sw_reset |=> !carrier_reset_n)
        else $error("Software request gave no carrier reset");
    a_reset_bounded: assert property (rst_cnt <= RST_CYCLES + 1)
        else $error("Carrier reset held too long");
    a_reset_release: assert property ($past(power_state) == spm_pkg::ST_RESET && power_state == spm_pkg::ST_ON
            |-> carrier_reset_n)
        else $error("Carrier reset still low in running state");
    a_wdog_set: assert property (watchdog_timeout |=> watchdog_event_out)
        else $error("Watchdog flag not set");
    a_wdog_clear: assert property (s_wdog_clear |=> !watchdog_event_out)
        else $error("Watchdog flag not cleared");
    a_pg_loss: assert property (pg_cnt > FILT_CYCLES + 5 |-> power_state != spm_pkg::ST_ON && !carrier_reset_n)
        else $error("Running on without power good");
endmodule

bind spm_power_manager spm_pm_chk #(.FILT_CYCLES(FILT_CYCLES), .RST_CYCLES(RST_CYCLES)) u_chk (
    .ref_clk(ref_clk), .srst(srst), .main_power_good(main_power_good),
    .watchdog_timeout(watchdog_timeout), .watchdog_clear(watchdog_clear), .sw_reset_req(sw_reset_req),
    .carrier_reset_n(carrier_reset_n), .suspend_warning_n(suspend_warning_n), .sleep_ram_n(sleep_ram_n),
    .sleep_disk_n(sleep_disk_n), .soft_off_n(soft_off_n), .watchdog_event_out(watchdog_event_out),
    .power_state(power_state));

/* File: dv/spm_carrier_model.sv */
// Carrier board model: buttons and wake sources idling at their pull-up levels, supplies starting low
`timescale 1ns/10ps
module spm_carrier_model (
    input  wire logic ref_clk,           // Clock
    input  wire logic sleep_ram_n,       // Suspend to RAM from the module
    output logic      power_button_n,    // Power button, pulled up
    output logic      reset_button_n,    // Reset button, pulled up
    output logic      main_power_good,   // Supply good
    output logic      main_12v_input,    // 12 V good
    output logic      pcie_wake_n,       // PCI Express wake, pulled up
    output logic      general_wake_n,    // General wake, pulled up
    output logic      supply_on_request  // Main rails enable
);
    logic [3:0] low_n;

    assign {general_wake_n, pcie_wake_n, reset_button_n, power_button_n} = low_n;
    assign supply_on_request = ~sleep_ram_n;

    initial begin
        low_n <= 4'hf;
        main_power_good <= 1'b0;
        main_12v_input <= 1'b0;
    end

    // Release goes back to the pull-up and stays quiet as long again, so the next press is seen
    task automatic press(input int ch, input int hold);
        @(posedge ref_clk);
        low_n[ch] <= 1'b0;
        repeat (hold) @(posedge ref_clk);
        low_n[ch] <= 1'b1;
        repeat (hold) @(posedge ref_clk);
    endtask

    task automatic supply(input logic pg, input logic v12);
        @(posedge ref_clk);
        main_power_good <= pg;
        main_12v_input <= v12;
    endtask
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the power and reset manager against a carrier model
`timescale 1ns/10ps
module testbench;
    localparam int HOLD  = 20; // Scaled stand-in for the least press width
    localparam int LIMIT = 20000;
    logic ref_clk, srst, ext_off;
    logic pbn, rbn, pg, v12, pwn, gwn;
    logic crn, swn, srn, sdn, son, wdo, sup_on;
    logic [3:0] ctl;
    spm_pkg::spm_sleep_e tgt;
    spm_pkg::spm_state_e power_state, last_st;
    spm_pkg::spm_cause_e reset_cause;
    spm_pkg::spm_state_e exp_q[$];
    spm_pkg::spm_state_e slp_st[3] = '{spm_pkg::ST_RAM, spm_pkg::ST_DISK, spm_pkg::ST_OFF};
    spm_pkg::spm_sleep_e slp_tg[3] = '{spm_pkg::SLP_RAM, spm_pkg::SLP_DISK, spm_pkg::SLP_OFF};
    int wake_ch[3] = '{2, 3, 0};
    int err_count, checked, cycles, seed, i;

    spm_power_manager #(.FILT_CYCLES(4), .RST_CYCLES(8), .WARN_CYCLES(4)) dut (
        .ref_clk(ref_clk), .srst(srst), .power_button_n(pbn), .reset_button_n(rbn),
        .main_power_good(pg), .main_12v_input(v12), .pcie_wake_n(pwn), .general_wake_n(gwn),
        .watchdog_timeout(ctl[2]), .watchdog_clear(ctl[3]), .sw_reset_req(ctl[0]), .sw_sleep_req(ctl[1]),
        .sw_sleep_target(tgt), .extended_soft_off(ext_off), .carrier_reset_n(crn), .suspend_warning_n(swn),
        .sleep_ram_n(srn), .sleep_disk_n(sdn), .soft_off_n(son), .watchdog_event_out(wdo),
        .power_state(power_state), .reset_cause(reset_cause));
    spm_carrier_model carrier (
        .ref_clk(ref_clk), .sleep_ram_n(srn), .power_button_n(pbn), .reset_button_n(rbn),
        .main_power_good(pg), .main_12v_input(v12), .pcie_wake_n(pwn), .general_wake_n(gwn),
        .supply_on_request(sup_on));

    always #2 ref_clk = ~ref_clk;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic note(input spm_pkg::spm_state_e a, input spm_pkg::spm_state_e b);
        exp_q.push_back(a);
        exp_q.push_back(b);
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 500) begin
            @(posedge ref_clk);
            n++;
        end
        chk(8'(exp_q.size()), 8'h00);
    endtask

    task automatic pulse(input logic [3:0] v, input spm_pkg::spm_sleep_e t);
        @(posedge ref_clk);
        ctl <= v;
        tgt <= t;
        @(posedge ref_clk);
        ctl <= 4'h0;
    endtask

    task automatic power_on(input int ch);
        exp_q.push_back(spm_pkg::ST_PWRUP);
        note(spm_pkg::ST_RESET, spm_pkg::ST_ON);
        carrier.press(ch, HOLD);
        drain();
        chk({6'h00, sup_on, crn}, 8'h01);
    endtask

    task automatic report_and_stop();
        $display("TB: %0d checks, %0d mismatches", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Every state change must match the oldest noted expectation
    always @(posedge ref_clk) begin
        cycles++;
        if (!srst && power_state !== last_st) begin
            if (exp_q.size() == 0)
                chk(8'(power_state), 8'(last_st));
            else
                chk(8'(power_state), 8'(exp_q.pop_front()));
        end
        last_st = power_state;
        if (cycles == LIMIT) begin
            err_count++;
            report_and_stop();
        end
    end

    initial begin
        ref_clk = 1'b0;
        srst <= 1'b1;
        ctl <= 4'h0;
        tgt <= spm_pkg::SLP_RAM;
        ext_off <= 1'b0;
        seed = 32'h45b38ecb;
        last_st = spm_pkg::ST_OFF;
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        carrier.supply(1'b1, 1'b1);
        power_on(0);
        for (i = 0; i < 4; i++)
            carrier.press(i, 1 + ($unsigned($random(seed)) % 2));
        $display("TB: power on and glitch tests done");
        note(spm_pkg::ST_RESET, spm_pkg::ST_ON);
        pulse(4'h1, spm_pkg::SLP_RAM);
        drain();
        chk(8'(reset_cause), 8'(spm_pkg::CAUSE_SOFTWARE));
        note(spm_pkg::ST_RESET, spm_pkg::ST_ON);
        carrier.press(1, 3 * HOLD);
        drain();
        chk(8'(reset_cause), 8'(spm_pkg::CAUSE_BUTTON));
        note(spm_pkg::ST_RESET, spm_pkg::ST_ON);
        pulse(4'h4, spm_pkg::SLP_RAM);
        #1;
        chk({7'h00, wdo}, 8'h01);
        drain();
        chk(8'(reset_cause), 8'(spm_pkg::CAUSE_WATCHDOG));
        note(spm_pkg::ST_RESET, spm_pkg::ST_ON);
        pulse(4'hc, spm_pkg::SLP_RAM);
        #1;
        chk({7'h00, wdo}, 8'h01);
        pulse(4'h8, spm_pkg::SLP_RAM);
        #1;
        chk({7'h00, wdo}, 8'h00);
        drain();
        $display("TB: reset source tests done");
        for (i = 0; i < 2; i++) begin
            exp_q.push_back(spm_pkg::ST_PWRUP);
            note(spm_pkg::ST_RESET, spm_pkg::ST_ON);
            carrier.supply(i != 0, i == 0);
            repeat (HOLD) @(posedge ref_clk);
            carrier.supply(1'b1, 1'b1);
            drain();
            chk(8'(reset_cause), (i == 0) ? 8'(spm_pkg::CAUSE_POWER) : 8'(spm_pkg::CAUSE_SUPPLY));
        end
        $display("TB: supply loss tests done");
        for (i = 0; i < 3; i++) begin
            note(spm_pkg::ST_WARN, slp_st[i]);
            pulse(4'h2, slp_tg[i]);
            drain();
            chk({3'h0, swn, sup_on, srn, sdn, son}, (i == 0) ? 8'h0b : (i == 1) ? 8'h09 : 8'h08);
            if (i == 2) begin
                ext_off <= 1'b1;
                carrier.press(3, HOLD);
            end
            power_on(wake_ch[i]);
            ext_off <= 1'b0;
        end
        note(spm_pkg::ST_WARN, spm_pkg::ST_OFF);
        carrier.press(0, HOLD);
        drain();
        power_on(3);
        $display("TB: sleep and wake tests done");
        report_and_stop();
    end
endmodule
